// [testbench/dcs_ctrl_model.sv]
// bus controller model issuing single-bit discrete commands
`timescale 1ns/100ps
module dcs_ctrl_model (
  input wire logic ref_clk,
  output logic cmdValid,
  output logic [2:0] cmdBitSel,
  output logic cmdBitValue
);
  initial
  begin
    cmdValid = 1'b0;
    cmdBitSel = 3'h0;
    cmdBitValue = 1'b0;
  end
  // one bit per command; idle fields are inverted so stale values never look valid
  task automatic send(input logic [2:0] sel, input logic val);
    @(negedge ref_clk);
    cmdValid = 1'b1;
    cmdBitSel = sel;
    cmdBitValue = val;
    @(negedge ref_clk);
    cmdValid = 1'b0;
    cmdBitSel = ~sel;
    cmdBitValue = ~val;
  endtask
endmodule

// [testbench/dcs_discrete_bits_tb.sv]
// self-checking bench for the discrete command and status bit bank
`timescale 1ns/100ps
module dcs_discrete_bits_tb;
  import dcs_pkg::*;
  logic ref_clk, rst, clkEn, cmdValid, cmdBitValue, wpViolation, wpViolationClr;
  logic rdDiscrete, rdInternal, discreteValid, internalValid, pulse;
  logic cmdProcReset, cmdWdtDis, cmdRun, cmdMx, cmdZ, cmdPx, cmdMaint, cmdWp;
  logic [2:0] cmdBitSel;
  logic [7:0] sts, cmdLines, expCmd, outs;
  logic [15:0] discreteWord, internalWord, word;
  int bad_count, comparisons;
  // bit 0 is the held reset level, the other bits the dedicated outputs
  assign outs = {cmdWp, cmdMaint, cmdPx, cmdZ, cmdMx, cmdRun, cmdWdtDis, cmdLines[0]};
  dcs_ctrl_model u_ctrl (.ref_clk(ref_clk), .cmdValid(cmdValid), .cmdBitSel(cmdBitSel),
    .cmdBitValue(cmdBitValue));
  dcs_discrete_bits u_dut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .cmdValid(cmdValid),
    .cmdBitSel(cmdBitSel), .cmdBitValue(cmdBitValue), .stsDescriptorTableLoaded(sts[0]),
    .stsDownloadedCodeRunning(sts[1]), .stsWatchdogUpperBits(sts[3:2]),
    .stsMotorEnable(sts[4]), .stsAntennaNormal(sts[5]), .stsMaintenanceActive(sts[6]),
    .stsAntennaFault(sts[7]), .wpViolation(wpViolation), .wpViolationClr(wpViolationClr),
    .rdDiscrete(rdDiscrete), .rdInternal(rdInternal), .cmdProcReset(cmdProcReset),
    .cmdWatchdogDisable(cmdWdtDis), .cmdRunNotSleep(cmdRun), .cmdMinusXAntennaPower(cmdMx),
    .cmdZAntennaPower(cmdZ), .cmdPlusXAntennaPower(cmdPx), .cmdMaintenanceRequest(cmdMaint),
    .cmdWriteProtectDisable(cmdWp), .cmdLines(cmdLines), .discreteWord(discreteWord),
    .discreteValid(discreteValid), .internalWord(internalWord), .internalValid(internalValid));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobe for one cycle, the word is valid in the following cycle
  task automatic rd(input logic internal, output logic [15:0] w);
    @(negedge ref_clk);
    rdDiscrete = !internal;
    rdInternal = internal;
    @(negedge ref_clk);
    rdDiscrete = 1'b0;
    rdInternal = 1'b0;
    chk({15'h0, internal ? internalValid : discreteValid}, 16'h0001);
    w = internal ? internalWord : discreteWord;
  endtask
  task automatic cmd(input logic [2:0] sel, input logic val);
    u_ctrl.send(sel, val);
    expCmd[sel] = val;
    pulse = cmdProcReset;
    chk({8'h0, outs}, {8'h0, expCmd});
  endtask
  initial
  begin
    #200000;
    bad_count++;
    conclude();
  end
  initial
  begin
    {rst, clkEn, wpViolation, wpViolationClr, rdDiscrete, rdInternal} = 6'b110000;
    expCmd = 8'h00;
    sts = 8'h00;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    chk({8'h0, cmdLines}, 16'h0000);
    rd(1'b0, word);
    chk(word, 16'h0000);
    for (int n = 0; n < 8; n++)
    begin
      cmd(n[2:0], 1'b1);
      chk({15'h0, pulse}, {15'h0, n == 0});
      rd(1'b1, word);
      chk(word, 16'h0001 << n);
    end
    cmd(3'h0, 1'b1);
    chk({15'h0, pulse}, 16'h0000);
    cmd(3'h0, 1'b0);
    cmd(3'h0, 1'b1);
    chk({15'h0, pulse}, 16'h0001);
    cmd(3'h3, 1'b0);
    rd(1'b1, word);
    chk(word, 16'h0000);
    foreach (outs[i])
    begin
      sts = 8'h01 << i;
      rd(1'b0, word);
      chk(word, {sts, expCmd});
    end
    sts = 8'h0c;
    rd(1'b0, word);
    chk(word, {8'h0c, expCmd});
    @(negedge ref_clk);
    wpViolation = 1'b1;
    @(negedge ref_clk);
    wpViolation = 1'b0;
    rd(1'b1, word);
    chk(word, 16'h0100);
    @(negedge ref_clk);
    wpViolationClr = 1'b1;
    @(negedge ref_clk);
    wpViolationClr = 1'b0;
    rd(1'b1, word);
    chk(word, 16'h0000);
    @(negedge ref_clk);
    {wpViolation, wpViolationClr} = 2'b11;
    @(negedge ref_clk);
    {wpViolation, wpViolationClr} = 2'b00;
    rd(1'b1, word);
    chk(word, 16'h0100);
    clkEn = 1'b0;
    u_ctrl.send(3'h1, 1'b0);
    clkEn = 1'b1;
    chk({8'h0, cmdLines}, {8'h0, expCmd});
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    expCmd = 8'h00;
    chk({8'h0, cmdLines}, 16'h0000);
    rd(1'b1, word);
    chk(word, 16'h0000);
    cmd(3'h0, 1'b1);
    chk({15'h0, pulse}, 16'h0001);
    conclude();
  end
endmodule

// [verilog/dcs_discrete_bits.sv]
// discrete command latches, status sampling and the two readable words
`timescale 1ns/100ps
module dcs_discrete_bits
  import dcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clkEn,
  // single-bit discrete command from the remote terminal
  input wire logic cmdValid,
  input wire logic [2:0] cmdBitSel,
  input wire logic cmdBitValue,
  // status lines from instrument logic
  input wire logic stsDescriptorTableLoaded,
  input wire logic stsDownloadedCodeRunning,
  input wire logic [1:0] stsWatchdogUpperBits,
  input wire logic stsMotorEnable,
  input wire logic stsAntennaNormal,
  input wire logic stsMaintenanceActive,
  input wire logic stsAntennaFault,
  input wire logic wpViolation,
  input wire logic wpViolationClr,
  // word reads by the bus side
  input wire logic rdDiscrete,
  input wire logic rdInternal,
  output logic cmdProcReset,
  output logic cmdWatchdogDisable,
  output logic cmdRunNotSleep,
  output logic cmdMinusXAntennaPower,
  output logic cmdZAntennaPower,
  output logic cmdPlusXAntennaPower,
  output logic cmdMaintenanceRequest,
  output logic cmdWriteProtectDisable,
  output logic [DISC_W-1:0] cmdLines,
  output logic [WORD_W-1:0] discreteWord,
  output logic discreteValid,
  output logic [WORD_W-1:0] internalWord,
  output logic internalValid
);
  import dcs_pkg::*;

  // command levels, last key, sticky violation flag, reset pulse and the two read snapshots with their valids are the state
  logic [7:0] cmd_q, cmd_d;
  logic [7:0] key_q, key_d;
  logic resetPulse_q, resetPulse_d;
  logic wpFlag_q, wpFlag_d;
  logic [15:0] discWord_q, discWord_d;
  logic [15:0] intWord_q, intWord_d;
  logic discValid_q, discValid_d;
  logic intValid_q, intValid_d;
  logic [7:0] stsNow;

  always_comb
  begin
    stsNow = 8'h00;
    stsNow[STS_TABLES] = stsDescriptorTableLoaded;
    stsNow[STS_STS_DOWNLOADED_CODE_RUNNING] = stsDownloadedCodeRunning;
    // top bits pass as a plain code; higher code means less time left
    stsNow[STS_WDT_LO] = stsWatchdogUpperBits[0];
    stsNow[STS_WDT_HI] = stsWatchdogUpperBits[1];
    stsNow[STS_MOTOR] = stsMotorEnable;
    stsNow[STS_ANT_OK] = stsAntennaNormal;
    stsNow[STS_MAINT] = stsMaintenanceActive;
    stsNow[STS_ANT_FAULT] = stsAntennaFault;
  end

  always_comb
  begin
    cmd_d = cmd_q;
    key_d = key_q;
    resetPulse_d = 1'b0;
    wpFlag_d = wpFlag_q;
    discWord_d = discWord_q;
    intWord_d = intWord_q;
    discValid_d = 1'b0;
    intValid_d = 1'b0;
    if (cmdValid)
    begin
      cmd_d[cmdBitSel] = cmdBitValue;
      // key records only the altered bit; zero when that bit was cleared
      key_d = cmdBitValue ? (8'h01 << cmdBitSel) : KEY_RESET_VAL;
      // one-cycle reset only on a rising edge of the reset line
      resetPulse_d = (cmdBitSel == BIT_ZERO) && cmdBitValue && !cmd_q[CMD_RESET];
    end
    // set beats clear for the only flag the instrument can touch
    if (wpViolation)
      wpFlag_d = 1'b1;
    else if (wpViolationClr)
      wpFlag_d = 1'b0;
    // reads take a snapshot, so the bus never sees a word torn across two cycles
    if (rdDiscrete)
    begin
      discWord_d = {stsNow, cmd_q};
      discValid_d = 1'b1;
    end
    if (rdInternal)
    begin
      intWord_d = {7'h00, wpFlag_q, key_q & STS_LOW_MASK};
      intValid_d = 1'b1;
    end
  end

  // rst clears every register even with clkEn low; otherwise clkEn low freezes them all, the reset pulse included
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cmd_q <= CMD_RESET_VAL;
      key_q <= KEY_RESET_VAL;
      resetPulse_q <= 1'b0;
      wpFlag_q <= 1'b0;
      discWord_q <= WORD_RESET_VAL;
      intWord_q <= WORD_RESET_VAL;
      discValid_q <= 1'b0;
      intValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      cmd_q <= cmd_d;
      key_q <= key_d;
      resetPulse_q <= resetPulse_d;
      wpFlag_q <= wpFlag_d;
      discWord_q <= discWord_d;
      intWord_q <= intWord_d;
      discValid_q <= discValid_d;
      intValid_q <= intValid_d;
    end
  end

  // internal word leaves only toward the bus side, never into the instrument
  assign internalWord = intWord_q;
  assign internalValid = intValid_q;
  assign discreteWord = discWord_q;
  assign discreteValid = discValid_q;
  assign cmdLines = cmd_q;
  assign cmdProcReset = resetPulse_q;
  assign cmdWatchdogDisable = cmd_q[CMD_WDT_DIS];
  assign cmdRunNotSleep = cmd_q[CMD_RUN];
  assign cmdMinusXAntennaPower = cmd_q[CMD_ANT_MX];
  assign cmdZAntennaPower = cmd_q[CMD_ANT_Z];
  assign cmdPlusXAntennaPower = cmd_q[CMD_ANT_PX];
  assign cmdMaintenanceRequest = cmd_q[CMD_MAINT];
  assign cmdWriteProtectDisable = cmd_q[CMD_WP_DIS];

  // reset line: one pulse per rising edge, none while held high
  a_reset_edge: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == BIT_ZERO && cmdBitValue && !cmdLines[CMD_RESET])
    |=> cmdProcReset)
    else $error("reset edge gave no pulse");

  a_reset_single: assert property (@(posedge ref_clk) disable iff (rst)
    cmdProcReset
    |=> !cmdProcReset || $past(clkEn) == 1'b0)
    else $error("reset held high");

  a_hold_high: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == BIT_ZERO && cmdLines[CMD_RESET])
    |=> !cmdProcReset)
    else $error("held reset line pulsed again");

  a_pulse_line: assert property (@(posedge ref_clk) disable iff (rst)
    cmdProcReset
    |-> cmdLines[CMD_RESET])
    else $error("reset pulse without reset line");

  // command levels hold, change one bit at a time, and freeze with clkEn
  a_cmd_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !cmdValid)
    |=> $stable(cmdLines))
    else $error("command line moved");

  a_cmd_write: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid)
    |=> cmdLines[$past(cmdBitSel)] == $past(cmdBitValue))
    else $error("command bit not written");

  a_freeze_all: assert property (@(posedge ref_clk) disable iff (rst)
    !clkEn
    |=> $stable(cmdLines) && $stable(cmdProcReset) && $stable(internalWord)
      && $stable(discreteWord))
    else $error("state moved while frozen");

  a_reset_state: assert property (@(posedge ref_clk)
    rst
    |=> cmdLines == CMD_RESET_VAL && !cmdProcReset && !cmdRunNotSleep)
    else $error("reset left a line high");

  // key and violation flag seen through the internal word
  a_key_set: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitValue) ##1 (clkEn && !cmdValid)
      ##1 (clkEn && rdInternal && !cmdValid)
    |=> internalWord[7:0] == (8'h01 << $past(cmdBitSel, 3)))
    else $error("set key wrong");

  a_key_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && !cmdBitValue) ##1 (clkEn && !cmdValid)
      ##1 (clkEn && rdInternal && !cmdValid)
    |=> internalWord[7:0] == 8'h00)
    else $error("cleared key not zero");

  a_int_upper: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && rdInternal)
    |=> internalValid && internalWord[15:9] == 7'h00)
    else $error("internal word upper bits set");

  a_wp_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && wpViolation) ##1 (clkEn && !wpViolationClr)
      ##1 (clkEn && rdInternal && !wpViolationClr)
    |=> internalWord[8])
    else $error("violation flag lost");

  a_wp_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && wpViolationClr && !wpViolation) ##1 (clkEn && !wpViolation)
      ##1 (clkEn && rdInternal && !wpViolation)
    |=> !internalWord[8])
    else $error("violation flag not cleared");

  // discrete word packing
  a_word_pack: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && rdDiscrete)
    |=> discreteValid && discreteWord[15] == $past(stsAntennaFault)
      && discreteWord[7:0] == $past(cmdLines))
    else $error("discrete word packing wrong");

  a_sts_pack: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && rdDiscrete)
    |=> discreteWord[15:8] == $past({stsAntennaFault, stsMaintenanceActive, stsAntennaNormal,
      stsMotorEnable, stsWatchdogUpperBits, stsDownloadedCodeRunning, stsDescriptorTableLoaded}))
    else $error("status byte wrong");

  a_wdt_bits: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && rdDiscrete)
    |=> discreteWord[11:10] == $past(stsWatchdogUpperBits))
    else $error("watchdog bits wrong");

  a_disc_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !rdDiscrete)
    |=> !discreteValid)
    else $error("discrete valid without read");

  a_int_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && !rdInternal)
    |=> !internalValid)
    else $error("internal valid without read");

  // each dedicated line follows the command to its own bit
  a_run_map: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_RUN))
    |=> cmdRunNotSleep == $past(cmdBitValue))
    else $error("run line mismatch");

  a_wdt_dis_map: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_WDT_DIS))
    |=> cmdWatchdogDisable == $past(cmdBitValue))
    else $error("watchdog disable line mismatch");

  a_ant_mx: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_ANT_MX))
    |=> cmdMinusXAntennaPower == $past(cmdBitValue))
    else $error("minus x antenna line mismatch");

  a_ant_z: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_ANT_Z))
    |=> cmdZAntennaPower == $past(cmdBitValue))
    else $error("z antenna line mismatch");

  a_ant_px: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_ANT_PX))
    |=> cmdPlusXAntennaPower == $past(cmdBitValue))
    else $error("plus x antenna line mismatch");

  a_maint_map: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_MAINT))
    |=> cmdMaintenanceRequest == $past(cmdBitValue))
    else $error("maintenance line mismatch");

  a_wp_dis_map: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && cmdValid && cmdBitSel == 3'(CMD_WP_DIS))
    |=> cmdWriteProtectDisable == $past(cmdBitValue))
    else $error("write protect line mismatch");
endmodule

// [verilog/dcs_pkg.sv]
// package of constants for the discrete command and status bit bank
package dcs_pkg;
  localparam int DISC_W = 8;
  localparam int WORD_W = 16;
  // command line bit positions
  localparam int CMD_RESET = 0;
  localparam int CMD_WDT_DIS = 1;
  localparam int CMD_RUN = 2;
  localparam int CMD_ANT_MX = 3;
  localparam int CMD_ANT_Z = 4;
  localparam int CMD_ANT_PX = 5;
  localparam int CMD_MAINT = 6;
  localparam int CMD_WP_DIS = 7;
  // status line bit positions
  localparam int STS_TABLES = 0;
  localparam int STS_STS_DOWNLOADED_CODE_RUNNING = 1;
  localparam int STS_WDT_LO = 2;
  localparam int STS_WDT_HI = 3;
  localparam int STS_MOTOR = 4;
  localparam int STS_ANT_OK = 5;
  localparam int STS_MAINT = 6;
  localparam int STS_ANT_FAULT = 7;
  // housekeeping byte offsets of command and status bytes
  localparam logic [7:0] HK_CMD_OFFSET = 8'h14;
  localparam logic [7:0] HK_STS_OFFSET = 8'h15;
  // reset values: all lines low, so the run line powers up asleep
  localparam logic [7:0] CMD_RESET_VAL = 8'h00;
  localparam logic [7:0] KEY_RESET_VAL = 8'h00;
  localparam logic [15:0] WORD_RESET_VAL = 16'h0000;
  localparam logic [7:0] STS_LOW_MASK = 8'hff;
  localparam logic [2:0] BIT_ZERO = 3'h0;
endpackage
